/* File: testbench/sts_ctl_model.sv */
// Serial controller model: shifts one frame of any length.
// Assumes the caller keeps frames apart; the clock stands low outside them.
`timescale 1ns/10ps
module sts_ctl_model (
  output logic SCLK,
  output logic CS_N,
  output logic SDI,
  input wire logic SDO
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    SDI = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, input int nb,
      output logic [15:0] r);
    int k;
    r = 16'h0000;
    CS_N = 1'b0;
    #30;
    for (k = 0; k < nb; k++) begin
      SCLK = 1'b1;
      SDI = (k < 16) ? w[15-k] : ~w[0];
      #6;
      SCLK = 1'b0;
      r = {r[14:0], SDO};
      #6;
    end
    CS_N = 1'b1;
    SDI = ~SDI;
    #400;
  endtask
endmodule

/* File: testbench/sts_top_chk.sv */
// Concurrent checks on the serial target top level ports.
// Assumes one CLK domain and SYS_RST high for at least one edge.
`timescale 1ns/10ps
module sts_top_chk (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CHIP_SELECT_ACTIVE_LOW,
  input wire logic SLEEP_PIN_ACTIVE_LOW,
  input wire logic DRIVER_DISABLE_PIN,
  input wire logic DRV_FAULT_EVT,
  input wire logic SDO_OE,
  input wire logic FAULT_OUTPUT_ACTIVE_LOW_OE,
  input wire logic FETS_EN,
  input wire logic REGULATORS_EN,
  input wire logic SERIAL_PORT_EN,
  input wire logic [sts_pkg::NCFG*8-1:0] CONFIG_OUT,
  input wire logic [7:0] IC_STATUS,
  input wire logic [7:0] STATUS_TWO
);
  import sts_pkg::*;
  // ----------------------------------------------------------------------
  // Pin level counters
  // ----------------------------------------------------------------------
  logic [11:0] lo_cnt;
  logic [11:0] hi_cnt;
  always_ff @(posedge CLK) begin
    if (SYS_RST || SLEEP_PIN_ACTIVE_LOW) lo_cnt <= 12'h000;
    else if (lo_cnt != 12'hfff) lo_cnt <= lo_cnt + 12'h001;
    if (SYS_RST || !SLEEP_PIN_ACTIVE_LOW) hi_cnt <= 12'h000;
    else if (hi_cnt != 12'hfff) hi_cnt <= hi_cnt + 12'h001;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_drv_hold;
    DRIVER_DISABLE_PIN [*4];
  endsequence
  sequence s_drv_evt;
    DRIVER_DISABLE_PIN [*5] ##0 (DRV_FAULT_EVT && !IC_STATUS[0]);
  endsequence
  AST_SLEEP_OFF: assert property (!REGULATORS_EN |->
    !SERIAL_PORT_EN && !FETS_EN) else $error("port or switches on in sleep");
  AST_SLEEP_DELAY: assert property ($fell(REGULATORS_EN) |->
    lo_cnt >= SLEEP_CYC - 12'h001 && lo_cnt <= SLEEP_CYC + 12'h008)
    else $error("sleep entry at wrong time");
  AST_WAKE_DELAY: assert property ($rose(SERIAL_PORT_EN) |->
    hi_cnt >= WAKE_CYC) else $error("port ready before wake delay");
  AST_OPER: assert property (SERIAL_PORT_EN |-> REGULATORS_EN)
    else $error("port on without regulators");
  AST_FLT_OFF: assert property (IC_STATUS[0] |->
    !FETS_EN && FAULT_OUTPUT_ACTIVE_LOW_OE) else $error("fault not held");
  AST_DRIVER_DISABLE_PIN: assert property (s_drv_hold |-> !FETS_EN)
    else $error("switches on while disabled");
  AST_DRIVER_DISABLE_PIN_FLT: assert property (s_drv_evt |=> !IC_STATUS[0])
    else $error("driver fault taken while disabled");
  AST_IDLE_HIZ: assert property (CHIP_SELECT_ACTIVE_LOW |-> !SDO_OE)
    else $error("output driven while deselected");
  AST_SUMMARY: assert property (|STATUS_TWO[2:0] |-> IC_STATUS[5])
    else $error("summary flag missing");
  AST_SLEEP_DFLT: assert property (!REGULATORS_EN ##1 !REGULATORS_EN |->
    CONFIG_OUT == '0 && STATUS_TWO == 8'h00) else $error("not defaulted");
endmodule
bind sts_top sts_top_chk chk_i (.CLK(CLK), .SYS_RST(SYS_RST),
  .CHIP_SELECT_ACTIVE_LOW(CHIP_SELECT_ACTIVE_LOW),
  .SLEEP_PIN_ACTIVE_LOW(SLEEP_PIN_ACTIVE_LOW),
  .DRIVER_DISABLE_PIN(DRIVER_DISABLE_PIN), .DRV_FAULT_EVT(DRV_FAULT_EVT),
  .SDO_OE(SDO_OE), .FAULT_OUTPUT_ACTIVE_LOW_OE(FAULT_OUTPUT_ACTIVE_LOW_OE),
  .FETS_EN(FETS_EN), .REGULATORS_EN(REGULATORS_EN),
  .SERIAL_PORT_EN(SERIAL_PORT_EN), .CONFIG_OUT(CONFIG_OUT),
  .IC_STATUS(IC_STATUS), .STATUS_TWO(STATUS_TWO));

/* File: testbench/sts_top_test.sv */
// Self-checking bench for the serial target with sleep control.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/10ps
module sts_top_test;
  import sts_pkg::*;
  logic CLK, SYS_RST, SLEEP_PIN_ACTIVE_LOW, DRIVER_DISABLE_PIN;
  logic SUPPLY_OK, DRV_FAULT_EVT;
  wire logic SCLK, CHIP_SELECT_ACTIVE_LOW, SDI, SDO_O, SDO_OE, sdo_line;
  wire logic FLT_O, FLT_OE, FLT_I, FETS_EN, REGULATORS_EN, SERIAL_PORT_EN;
  wire logic [NCFG*8-1:0] CONFIG_OUT;
  wire logic [7:0] IC_STATUS, STATUS_TWO;
  int err_count = 0;
  int num_checks = 0;
  int i;
  logic [15:0] r;
  logic [5:0] ea [4] = '{6'h0d, 6'h03, 6'h03, 6'h03};
  int en [4] = '{16, 15, 17, 16};
  logic eb [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0] es [4] = '{8'h01, 8'h02, 8'h02, 8'h04};
  // Released lines: a toggling pattern on data, a pull-up on the fault pin.
  assign sdo_line = SDO_OE ? SDO_O : CLK;
  assign FLT_I = FLT_OE ? FLT_O : 1'b1;
  sts_ctl_model mdl (.SCLK(SCLK), .CS_N(CHIP_SELECT_ACTIVE_LOW), .SDI(SDI),
    .SDO(sdo_line));
  sts_top uut (.CLK(CLK), .SYS_RST(SYS_RST), .SCLK(SCLK),
    .CHIP_SELECT_ACTIVE_LOW(CHIP_SELECT_ACTIVE_LOW), .SDI(SDI),
    .SDO_O(SDO_O), .SDO_OE(SDO_OE),
    .SLEEP_PIN_ACTIVE_LOW(SLEEP_PIN_ACTIVE_LOW),
    .DRIVER_DISABLE_PIN(DRIVER_DISABLE_PIN), .SUPPLY_OK(SUPPLY_OK),
    .DRV_FAULT_EVT(DRV_FAULT_EVT), .FAULT_OUTPUT_ACTIVE_LOW_I(FLT_I),
    .FAULT_OUTPUT_ACTIVE_LOW_O(FLT_O), .FAULT_OUTPUT_ACTIVE_LOW_OE(FLT_OE),
    .FETS_EN(FETS_EN), .REGULATORS_EN(REGULATORS_EN),
    .SERIAL_PORT_EN(SERIAL_PORT_EN), .CONFIG_OUT(CONFIG_OUT),
    .IC_STATUS(IC_STATUS), .STATUS_TWO(STATUS_TWO));
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wait_on(input bit regs, input logic lvl);
    int k;
    for (k = 0; k < 3000; k++) begin
      if ((regs ? REGULATORS_EN : SERIAL_PORT_EN) === lvl) return;
      step(1);
    end
    err_count++;
    $display("wrong value at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic frame(input logic rw, input logic [5:0] a,
      input logic [7:0] d, input int nb, input logic bad);
    logic [15:0] w;
    w = {rw, a, 1'b0, d};
    w[8] = ^w ^ bad;
    mdl.xfer(w, nb, r);
    step(8);
  endtask
  task automatic pulse_drv_fault();
    DRV_FAULT_EVT = 1'b1;
    step(1);
    DRV_FAULT_EVT = 1'b0;
    step(2);
  endtask
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial begin
    SYS_RST = 1'b1;
    SLEEP_PIN_ACTIVE_LOW = 1'b1;
    DRIVER_DISABLE_PIN = 1'b0;
    SUPPLY_OK = 1'b1;
    DRV_FAULT_EVT = 1'b0;
    step(16);
    SYS_RST = 1'b0;
    wait_on(0, 1'b1);
    step(5);
    chk({13'h0, REGULATORS_EN, FETS_EN, FLT_OE}, 16'h0006);
    chk({15'h0, FLT_I}, 16'h0001);
    frame(0, 6'h03, 8'h5a, 16, 0);
    chk(r, 16'h0000);
    frame(1, 6'h03, 8'h00, 16, 0);
    chk(r, 16'h005a);
    frame(0, 6'h0b, 8'hc3, 16, 0);
    chk({8'h0, CONFIG_OUT[71:64]}, 16'h00c3);
    for (i = 0; i < 4; i++) begin
      frame(0, ea[i], 8'hff, en[i], eb[i]);
      chk({8'h0, STATUS_TWO}, {8'h0, es[i]});
      chk({8'h0, CONFIG_OUT[7:0]}, 16'h005a);
      frame(0, REG_CLR, 8'h01, 16, 0);
      chk(r, 16'h2000);
      chk({8'h0, STATUS_TWO}, 16'h0000);
    end
    pulse_drv_fault();
    chk({13'h0, IC_STATUS[0], FETS_EN, FLT_OE}, 16'h0005);
    frame(0, 6'h03, 8'h11, 15, 0);
    SLEEP_PIN_ACTIVE_LOW = 1'b0;
    step(500);
    SLEEP_PIN_ACTIVE_LOW = 1'b1;
    step(8);
    chk({5'h0, STATUS_TWO, IC_STATUS[0], FETS_EN, SERIAL_PORT_EN},
      16'h0003);
    chk({8'h0, CONFIG_OUT[7:0]}, 16'h005a);
    DRIVER_DISABLE_PIN = 1'b1;
    step(6);
    pulse_drv_fault();
    chk({13'h0, IC_STATUS[0], FETS_EN, SERIAL_PORT_EN}, 16'h0001);
    DRIVER_DISABLE_PIN = 1'b0;
    step(6);
    chk({15'h0, FETS_EN}, 16'h0001);
    SLEEP_PIN_ACTIVE_LOW = 1'b0;
    step(1100);
    chk({13'h0, REGULATORS_EN, SERIAL_PORT_EN, FLT_OE}, 16'h0005);
    chk({15'h0, FLT_I}, 16'h0000);
    wait_on(1, 1'b0);
    frame(0, 6'h03, 8'h77, 15, 0);
    chk({8'h0, STATUS_TWO}, 16'h0000);
    chk(CONFIG_OUT[15:0], 16'h0000);
    SLEEP_PIN_ACTIVE_LOW = 1'b1;
    wait_on(0, 1'b1);
    step(5);
    frame(1, 6'h03, 8'h00, 16, 0);
    chk(r, 16'h0000);
    tally_and_finish();
  end
endmodule

/* File: verilog/sts_link.sv */
// Serial-clock front end: shifts the frame in and the response out.
// Assumes the core holds link_clr high between frames and in sleep.
`timescale 1ns/10ps
module sts_link (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo_o,
  sts_link_if.link lnk
);
  import sts_pkg::*;

  sts_link_s cur;
  sts_link_s nxt;
  logic sdo_ff;
  logic nxt_sdo;
  logic [15:0] tx_word;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------------
  // Receive on the falling edge
  // ----------------------------------------------------------------------
  always_comb begin
    nxt = cur;
    if (!cs_n) begin
      nxt.rx = {cur.rx[14:0], sdi};
      if (cur.cnt != CNT_SAT) begin
        nxt.cnt = cur.cnt + 5'h01;
      end
      if (cur.cnt == 5'h07) begin
        nxt.addr = cur.rx[5:0];
      end
    end
  end

  always_ff @(negedge sclk or posedge lnk.link_clr) begin
    if (lnk.link_clr) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit on the rising edge
  // ----------------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (cur.addr <= REG_LAST) begin
      rd_byte = lnk.snap[cur.addr[3:0]];
    end
    tx_word = {lnk.snap[REG_IC[3:0]], rd_byte};
    nxt_sdo = 1'h0;
    if (cur.cnt < FRAME_BITS) begin
      nxt_sdo = tx_word[4'(5'h0f - cur.cnt)];
    end
  end

  // A separate rising-edge flop keeps data changes away from sampling.
  always_ff @(posedge sclk or posedge lnk.link_clr) begin
    if (lnk.link_clr) begin
      sdo_ff <= 1'h0;
    end else if (!cs_n) begin
      sdo_ff <= nxt_sdo;
    end
  end

  // The first bit must stand before any clock edge arrives.
  assign sdo_o = (cur.cnt == 5'h00) ? tx_word[15] : sdo_ff;
  assign lnk.bit_cnt = cur.cnt;
  assign lnk.rx_word = cur.rx;

endmodule

/* File: verilog/sts_link_if.sv */
// Signals between the system-clock core and the serial-clock front end.
// The table and clear are static while a frame is in progress.
`timescale 1ns/10ps
interface sts_link_if;
  import sts_pkg::*;
  logic link_clr;
  sts_table_t snap;
  logic [4:0] bit_cnt;
  logic [15:0] rx_word;

  modport core (output link_clr, output snap, input bit_cnt, input rx_word);
  modport link (input link_clr, input snap, output bit_cnt, output rx_word);
endinterface

/* File: verilog/sts_pkg.sv */
// Constants and types for the serial target with sleep and fault control.
// Assumes a 200 MHz system clock and a serial clock from the controller.
package sts_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int T_SLEEP_NS = 10000;
  localparam int T_WAKE_NS = 10000;
  localparam int T_RST_NS = 5000;
  localparam logic [11:0] SLEEP_CYC = 12'((T_SLEEP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] WAKE_CYC = 12'((T_WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] RST_CYC = 12'(T_RST_NS / CLK_NS);

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CNT_SAT = 5'h11;
  localparam int RW_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 9;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int NREG = 13;
  localparam int NCFG = 10;
  localparam logic [5:0] REG_IC = 6'h00;
  localparam logic [5:0] REG_ST1 = 6'h01;
  localparam logic [5:0] REG_ST2 = 6'h02;
  localparam logic [5:0] REG_CFG_FIRST = 6'h03;
  localparam logic [5:0] REG_LAST = 6'h0c;
  localparam logic [5:0] REG_CLR = 6'h0c;
  localparam int CLR_BIT = 0;
  localparam int IC_FAULT_BIT = 0;
  localparam int IC_SPI_BIT = 5;
  localparam int ST2_ADDR_BIT = 0;
  localparam int ST2_SCLK_BIT = 1;
  localparam int ST2_PAR_BIT = 2;
  localparam logic [7:0] CFG_DEFAULT = 8'h00;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_WAKE = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_PULSE = 3'b011,
    ST_ENTER = 3'b100
  } sts_state_e;

  typedef logic [NREG-1:0][7:0] sts_table_t;

  typedef struct packed {
    logic [15:0] rx;
    logic [4:0] cnt;
    logic [5:0] addr;
  } sts_link_s;

endpackage

/* File: verilog/sts_top.sv */
// Sleep, wake, fault-clear and driver-off control with a 16-bit serial
// target port. Assumes protection detectors supply a fault event on CLK
// and the controller respects select gap and clock idle rules.
`timescale 1ns/10ps
module sts_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SCLK,
  input wire logic CHIP_SELECT_ACTIVE_LOW,
  input wire logic SDI,
  output logic SDO_O,
  output logic SDO_OE,
  input wire logic SLEEP_PIN_ACTIVE_LOW,
  input wire logic DRIVER_DISABLE_PIN,
  input wire logic SUPPLY_OK,
  input wire logic DRV_FAULT_EVT,
  input wire logic FAULT_OUTPUT_ACTIVE_LOW_I,
  output logic FAULT_OUTPUT_ACTIVE_LOW_O,
  output logic FAULT_OUTPUT_ACTIVE_LOW_OE,
  output logic FETS_EN,
  output logic REGULATORS_EN,
  output logic SERIAL_PORT_EN,
  output logic [sts_pkg::NCFG*8-1:0] CONFIG_OUT,
  output logic [7:0] IC_STATUS,
  output logic [7:0] STATUS_TWO
);
  import sts_pkg::*;

  typedef struct packed {
    sts_state_e st;
    logic [11:0] tmr;
    logic sl_s1;
    logic sl_s2;
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic sup_s1;
    logic sup_s2;
    logic off_s1;
    logic off_s2;
    logic [NCFG-1:0][7:0] cfg;
    logic flt_frame;
    logic flt_par;
    logic flt_addr;
    logic drv_flt;
    logic link_clr;
    sts_table_t snap;
    logic fault_oe;
    logic fets_en;
    logic reg_en;
    logic port_en;
  } sts_core_s;

  localparam sts_core_s CORE_RST = '{
    st: ST_SLEEP,
    tmr: 12'h000,
    cs_s1: 1'h1,
    cs_s2: 1'h1,
    cs_prev: 1'h1,
    cfg: {NCFG{CFG_DEFAULT}},
    link_clr: 1'h1,
    default: '0
  };

  sts_core_s cur;
  sts_core_s nxt;
  sts_table_t live;
  logic [7:0] ic_stat;
  logic [7:0] st2_stat;
  logic oper;
  logic pulse_clr;
  logic cmd_clr;
  logic frame_end;
  logic drv_event;
  logic [5:0] addr;
  logic [3:0] widx;
  logic [7:0] wdata;

  sts_link_if lnk ();

  // ----------------------------------------------------------------------
  // Serial-clock front end
  // ----------------------------------------------------------------------
  sts_link u_link (
    .sclk(SCLK),
    .cs_n(CHIP_SELECT_ACTIVE_LOW),
    .sdi(SDI),
    .sdo_o(SDO_O),
    .lnk(lnk.link)
  );

  assign lnk.link_clr = cur.link_clr;
  assign lnk.snap = cur.snap;

  // ----------------------------------------------------------------------
  // Status bytes and the readable table
  // ----------------------------------------------------------------------
  always_comb begin
    ic_stat = 8'h00;
    ic_stat[IC_FAULT_BIT] = cur.drv_flt;
    ic_stat[IC_SPI_BIT] = cur.flt_frame | cur.flt_par | cur.flt_addr;
    st2_stat = 8'h00;
    st2_stat[ST2_SCLK_BIT] = cur.flt_frame;
    st2_stat[ST2_PAR_BIT] = cur.flt_par;
    st2_stat[ST2_ADDR_BIT] = cur.flt_addr;
  end

  assign live[REG_IC[3:0]] = ic_stat;
  assign live[REG_ST1[3:0]] = 8'h00;
  assign live[REG_ST2[3:0]] = st2_stat;

  for (genvar i = 0; i < NCFG; i++) begin : g_live
    assign live[i + 3] = cur.cfg[i];
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    nxt = cur;
    pulse_clr = 1'h0;
    cmd_clr = 1'h0;
    addr = lnk.rx_word[ADDR_MSB:ADDR_LSB];
    widx = 4'(addr - REG_CFG_FIRST);
    wdata = lnk.rx_word[7:0];

    // Two-flop synchronisers for the sleep, select, supply and driver-disable pins.
    nxt.sl_s1 = SLEEP_PIN_ACTIVE_LOW;
    nxt.sl_s2 = cur.sl_s1;
    nxt.cs_s1 = CHIP_SELECT_ACTIVE_LOW;
    nxt.cs_s2 = cur.cs_s1;
    nxt.cs_prev = cur.cs_s2;
    nxt.sup_s1 = SUPPLY_OK;
    nxt.sup_s2 = cur.sup_s1;
    nxt.off_s1 = DRIVER_DISABLE_PIN;
    nxt.off_s2 = cur.off_s1;

    oper = cur.sup_s2 && (cur.st == ST_ACTIVE || cur.st == ST_PULSE);

    // Power state machine; the timer counts from WAKE and PULSE entry and runs on through ENTER.
    case (cur.st)
      ST_SLEEP: begin
        nxt.tmr = 12'h000;
        if (cur.sl_s2) begin
          nxt.st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!cur.sl_s2) begin
          nxt.st = ST_SLEEP;
          nxt.tmr = 12'h000;
        end else if (cur.tmr == WAKE_CYC - 12'h001) begin
          nxt.st = ST_ACTIVE;
          nxt.tmr = 12'h000;
        end else begin
          nxt.tmr = cur.tmr + 12'h001;
        end
      end
      ST_ACTIVE: begin
        if (!cur.sl_s2) begin
          nxt.st = ST_PULSE;
          nxt.tmr = 12'h000;
        end
      end
      ST_PULSE: begin
        if (cur.sl_s2) begin
          nxt.st = ST_ACTIVE;
          pulse_clr = 1'h1;
        end else if (cur.tmr == RST_CYC - 12'h001) begin
          nxt.st = ST_ENTER;
          nxt.tmr = cur.tmr + 12'h001;
        end else begin
          nxt.tmr = cur.tmr + 12'h001;
        end
      end
      ST_ENTER: begin
        if (cur.tmr >= SLEEP_CYC - 12'h001) begin
          nxt.st = ST_SLEEP;
          nxt.tmr = 12'h000;
        end else begin
          nxt.tmr = cur.tmr + 12'h001;
        end
      end
      default: begin
        nxt.st = ST_SLEEP;
        nxt.tmr = 12'h000;
      end
    endcase

    // A reset pulse clears the latched faults and nothing else.
    if (pulse_clr) begin
      nxt.flt_frame = 1'h0;
      nxt.flt_par = 1'h0;
      nxt.flt_addr = 1'h0;
      nxt.drv_flt = 1'h0;
    end

    // Frame decode on the synchronised rising edge of select.
    frame_end = oper && cur.cs_s2 && !cur.cs_prev;
    if (frame_end) begin
      if (lnk.bit_cnt != FRAME_BITS) begin
        nxt.flt_frame = 1'h1;
      end else if (^lnk.rx_word) begin
        nxt.flt_par = 1'h1;
      end else if (addr > REG_LAST) begin
        nxt.flt_addr = 1'h1;
      end else if (!lnk.rx_word[RW_BIT] && addr >= REG_CFG_FIRST) begin
        nxt.cfg[widx] = wdata;
        if (addr == REG_CLR) begin
          nxt.cfg[widx][CLR_BIT] = 1'h0;
          cmd_clr = wdata[CLR_BIT];
        end
      end
    end

    if (cmd_clr) begin
      nxt.flt_frame = 1'h0;
      nxt.flt_par = 1'h0;
      nxt.flt_addr = 1'h0;
      nxt.drv_flt = 1'h0;
    end

    // Driver faults are ignored while the driver is disabled; a new
    // event wins over a clear in the same cycle.
    drv_event = DRV_FAULT_EVT && oper && !cur.off_s2;
    if (drv_event) begin
      nxt.drv_flt = 1'h1;
    end

    // Sleep returns every port register and flag to its default.
    if (cur.st == ST_SLEEP) begin
      nxt.cfg = {NCFG{CFG_DEFAULT}};
      nxt.flt_frame = 1'h0;
      nxt.flt_par = 1'h0;
      nxt.flt_addr = 1'h0;
      nxt.drv_flt = 1'h0;
    end

    // Output enables follow the next state.
    nxt.reg_en = nxt.st != ST_SLEEP;
    nxt.port_en = cur.sup_s2 &&
                  (nxt.st == ST_ACTIVE || nxt.st == ST_PULSE);
    nxt.fets_en = nxt.port_en && !cur.off_s2 && !nxt.drv_flt;
    nxt.fault_oe = nxt.st == ST_WAKE || nxt.st == ST_ENTER ||
                   nxt.drv_flt;

    // The front end is held cleared between frames; the response table
    // is refreshed only then, so it stands still during a frame.
    nxt.link_clr = !nxt.port_en || (cur.cs_s2 && cur.cs_prev);
    if (cur.link_clr) begin
      nxt.snap = live;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cur <= CORE_RST;
    end else begin
      cur <= nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign SDO_OE = !CHIP_SELECT_ACTIVE_LOW && cur.port_en;
  assign FAULT_OUTPUT_ACTIVE_LOW_O = 1'h0;
  assign FAULT_OUTPUT_ACTIVE_LOW_OE = cur.fault_oe;
  assign FETS_EN = cur.fets_en;
  assign REGULATORS_EN = cur.reg_en;
  assign SERIAL_PORT_EN = cur.port_en;
  assign CONFIG_OUT = cur.cfg;
  assign IC_STATUS = ic_stat;
  assign STATUS_TWO = st2_stat;

endmodule
